// ===== rtl/guarded_watchdog_defines.vh
// constants shared by the guarded watchdog timer
//
// Contract
// - counter write enable loads only with bit7 zero
// - counter writable only while counter write enabled
// - control write enable loads only with bit5 zero
// - run and flag software writes act only while control-enabled
// - run enable loads when run guard written zero
// - flag cleared by writing zero with guard zero
// - guard bits always read as one
// - counter advances only while run enabled, default on
// - external reset restores run on, flag off
// - overflow sets the overflow reset flag
// - 8-bit counter from zero, overflow FF to 00
// - internal reset held 256 oscillator cycles
// - counting continues from software-written value
// - clock select picks prescaler tap or oscillator
// - clock source bits 7..4 read as one
// - counting starts automatically after reset release
`ifndef GUARDED_WATCHDOG_DEFINES_VH
`define GUARDED_WATCHDOG_DEFINES_VH
`define WDT_OFS_CTRL      8'h00
`define WDT_OFS_COUNT     8'h04
`define WDT_OFS_CLKSRC    8'h08
`define WDT_BIT_FLAG      0
`define WDT_BIT_FLAGGRD   1
`define WDT_BIT_RUN       2
`define WDT_BIT_RUNGRD    3
`define WDT_BIT_CTRLWE    4
`define WDT_BIT_CTRLWEGRD 5
`define WDT_BIT_CNTWE     6
`define WDT_BIT_CNTWEGRD  7
`define WDT_RST_COUNT     8'h00
`define WDT_RST_CLKSEL    4'hF
`define WDT_CLKSRC_RSVD   4'hF
`define WDT_CNT_MAX       8'hFF
`define WDT_PRESC_BITS    13
`define WDT_TAP_BASE      5
`define WDT_PULSE_OSC     9'h100
`define HTRANS_NONSEQ     2'h2
`endif

// ===== rtl/guarded_watchdog_timer.v
// guarded watchdog timer with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`include "guarded_watchdog_defines.vh"
`timescale 1ns/1ps
module guarded_watchdog_timer #(
   parameter PULSE_OSC_CYCLES = `WDT_PULSE_OSC
) (
   input  wire        clk_sys,
   input  wire        rst_b,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        dedicatedOscClock,
   output reg         internalReset,
   output reg         overflowResetFlag,
   output reg         runEnable
);

   // control and count state
   reg        cntWriteEn_q;
   reg        ctrlWriteEn_q;
   reg        runEnable_q;
   reg        flag_q;
   reg [7:0]  count_q;
   reg [3:0]  clockSel_q;
   reg [`WDT_PRESC_BITS-1:0] presc_q;
   reg        wrPend_q;
   reg [7:0]  wrAddr_q;
   reg        oscSync1_q;
   reg        oscSync2_q;
   reg        oscSync3_q;
   reg [8:0]  pulseCnt_q;

   // address phase capture: a write is held until its data phase
   wire addrPhase = hsel & hready & htrans[1];
   wire wrCtrl    = wrPend_q & (wrAddr_q == `WDT_OFS_CTRL);
   wire wrCount   = wrPend_q & (wrAddr_q == `WDT_OFS_COUNT);
   wire wrClk     = wrPend_q & (wrAddr_q == `WDT_OFS_CLKSRC);
   wire [7:0] wd  = hwdata[7:0];

   // oscillator edge seen in system domain; first stage only feeds second
   wire oscRise = oscSync2_q & ~oscSync3_q;

   // tap select: code 1xxx picks divide by 64 << low bits
   wire [2:0] tapIdx = clockSel_q[2:0];
   wire [`WDT_PRESC_BITS-1:0] prescNext = presc_q + {{(`WDT_PRESC_BITS-1){1'b0}}, 1'b1};
   wire [`WDT_PRESC_BITS-1:0] rollBits = presc_q & ~prescNext;
   wire tapTick = rollBits[`WDT_TAP_BASE + tapIdx];
   wire countTick = clockSel_q[3] ? tapTick : oscRise;
   wire stepEn    = runEnable_q & countTick;
   wire overflow  = stepEn & (count_q == `WDT_CNT_MAX) & ~wrCount;

   // bus side: zero wait state, always OKAY
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPend_q  <= 1'b0;
         wrAddr_q  <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wrPend_q  <= addrPhase & hwrite;
         wrAddr_q  <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addrPhase & ~hwrite) begin
            case (haddr[7:0])
               `WDT_OFS_CTRL:   hrdata <= {24'h000000, 1'b1, cntWriteEn_q, 1'b1, ctrlWriteEn_q,
                                           1'b1, runEnable_q, 1'b1, flag_q};
               `WDT_OFS_COUNT:  hrdata <= {24'h000000, count_q};
               `WDT_OFS_CLKSRC: hrdata <= {24'h000000, `WDT_CLKSRC_RSVD, clockSel_q};
               default:         hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // guarded control register; bits written only as a whole byte
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cntWriteEn_q  <= 1'b0;
         ctrlWriteEn_q <= 1'b0;
         runEnable_q   <= 1'b1;
         flag_q        <= 1'b0;
         clockSel_q    <= `WDT_RST_CLKSEL;
      end else begin
         if (wrCtrl & ~wd[`WDT_BIT_CNTWEGRD])
            cntWriteEn_q <= wd[`WDT_BIT_CNTWE];
         if (wrCtrl & ~wd[`WDT_BIT_CTRLWEGRD])
            ctrlWriteEn_q <= wd[`WDT_BIT_CTRLWE];
         // old enable gates this write, so stopping needs two writes
         if (wrCtrl & ctrlWriteEn_q & ~wd[`WDT_BIT_RUNGRD])
            runEnable_q <= wd[`WDT_BIT_RUN];
         // overflow set beats a simultaneous software clear
         if (overflow)
            flag_q <= 1'b1;
         else if (wrCtrl & ctrlWriteEn_q & ~wd[`WDT_BIT_FLAGGRD] & ~wd[`WDT_BIT_FLAG])
            flag_q <= 1'b0;
         if (wrClk)
            clockSel_q <= wd[3:0];
      end
   end

   // counter, prescaler and oscillator synchroniser
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count_q    <= `WDT_RST_COUNT;
         presc_q    <= {`WDT_PRESC_BITS{1'b0}};
         oscSync1_q <= 1'b0;
         oscSync2_q <= 1'b0;
         oscSync3_q <= 1'b0;
      end else begin
         presc_q    <= prescNext;
         oscSync1_q <= dedicatedOscClock;
         oscSync2_q <= oscSync1_q;
         oscSync3_q <= oscSync2_q;
         // software write wins over a coincident count step
         if (wrCount & cntWriteEn_q)
            count_q <= wd;
         else if (stepEn)
            count_q <= count_q + 8'h01;
      end
   end

   // reset pulse timed in oscillator edges, counted in system domain
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pulseCnt_q        <= 9'h000;
         internalReset     <= 1'b0;
         overflowResetFlag <= 1'b0;
         runEnable         <= 1'b1;
      end else begin
         if (overflow)
            pulseCnt_q <= PULSE_OSC_CYCLES[8:0];
         else if (pulseCnt_q != 9'h000 && oscRise)
            pulseCnt_q <= pulseCnt_q - 9'h001;
         internalReset     <= overflow | (pulseCnt_q != 9'h000);
         overflowResetFlag <= flag_q;
         runEnable         <= runEnable_q;
      end
   end

endmodule

// ===== verification/guarded_watchdog_timer_assertions.sv
// port assertions for the guarded watchdog timer
`timescale 1ns/1ps
module guarded_watchdog_timer_assertions (
   input logic        clk_sys,
   input logic        rst_b,
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [31:0] hrdata,
   input logic        internalReset,
   input logic        overflowResetFlag,
   input logic        runEnable
);
   // address phases; hready is always high here, so it is left out
   wire ctrlWr = hsel && htrans[1] && hwrite && haddr == 32'h0;
   wire ctrlRd = hsel && htrans[1] && !hwrite && haddr == 32'h0;
   wire srcRd  = hsel && htrans[1] && !hwrite && haddr == 32'h8;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // a reset pulse shorter than this is too short for any oscillator slower than clk_sys/4
   sequence pulseHeld;
      internalReset [*8];
   endsequence
   chk_guard_read: assert property (ctrlRd |=> (hrdata[7:0] & 8'hAA) == 8'hAA)
      else $error("guard bit read as zero");
   chk_rsvd_read: assert property (srcRd |=> hrdata[7:4] == 4'hF)
      else $error("reserved clock source bits not one");
   chk_run_guarded: assert property ($fell(runEnable) |-> $past(ctrlWr, 2) || $past(ctrlWr, 3))
      else $error("run enable dropped without a control write");
   chk_flag_cleared: assert property ($fell(overflowResetFlag) |-> $past(ctrlWr, 2) || $past(ctrlWr, 3))
      else $error("flag cleared without a control write");
   chk_flag_on_ovf: assert property ($rose(internalReset) |-> ##[0:2] overflowResetFlag)
      else $error("overflow did not set the flag");
   chk_pulse_hold: assert property ($rose(internalReset) |-> pulseHeld)
      else $error("internal reset pulse too short");
   chk_ovf_running: assert property ($rose(internalReset) |-> $past(runEnable))
      else $error("overflow while stopped");
   chk_reset_state: assert property ($rose(rst_b) |-> runEnable && !overflowResetFlag)
      else $error("wrong run or flag after reset");
endmodule
bind guarded_watchdog_timer guarded_watchdog_timer_assertions i_chk (.clk_sys, .rst_b, .hsel, .haddr, .htrans,
   .hwrite, .hrdata, .internalReset, .overflowResetFlag, .runEnable);

// ===== verification/guarded_watchdog_timer_tb.sv
// self-checking bench for the guarded watchdog timer
`timescale 1ns/1ps
module guarded_watchdog_timer_tb;
   localparam int OSCH = 10;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        hwrite = 1'b0;
   logic        dedicatedOscClock = 1'b0;
   logic        oscOn = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, internalReset, overflowResetFlag, runEnable;
   int          n_mismatch = 0, n_tests = 0, k, oscDiv = 0;
   guarded_watchdog_timer #(.PULSE_OSC_CYCLES(4)) i_dut (.clk_sys, .rst_b, .hsel(1'b1), .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dedicatedOscClock,
      .internalReset, .overflowResetFlag, .runEnable);
   initial forever #12.5 clk_sys = ~clk_sys;
   // oscillator stand-in, period 2*OSCH cycles: well under clk_sys/4 as the synchroniser needs
   always @(posedge clk_sys) begin
      oscDiv <= (oscDiv == OSCH - 1) ? 0 : oscDiv + 1;
      if (oscOn && oscDiv == OSCH - 1) dedicatedOscClock <= ~dedicatedOscClock;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, seen);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bounded wait for a level; running out counts as a mismatch
   task automatic waitFor(input logic lvl, input int lim);
      for (k = 0; internalReset !== lvl; k++) begin
         if (k > lim) begin
            n_mismatch++;
            tally_and_finish();
         end
         @(posedge clk_sys);
      end
   endtask
   task automatic edgeRdy;
      int t = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) begin
         if (++t > 50) begin
            n_mismatch++;
            tally_and_finish();
         end
         @(posedge clk_sys);
      end
   endtask
   // one single transfer: address phase, then data phase; read data taken at its closing edge
   task automatic bus(input logic w, input logic [31:0] a, d);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      edgeRdy();
      htrans <= 2'h0;
      hwdata <= d;
      edgeRdy();
      rd = hrdata;
   endtask
   task automatic rdChk(input string what, input logic [31:0] a, exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      rdChk("ctrl", 32'h0, 32'hAE);
      rdChk("clksrc", 32'h8, 32'hFF);
      rdChk("unmapped", 32'hC, 32'h0);
      bus(1'b1, 32'h4, 32'h55);
      rdChk("count locked", 32'h4, 32'h00);
      bus(1'b1, 32'h0, 32'hC0);
      rdChk("cnt enable guarded", 32'h0, 32'hAE);
      bus(1'b1, 32'h0, 32'h40);
      rdChk("cnt enable set", 32'h0, 32'hEE);
      bus(1'b1, 32'h4, 32'hFD);
      rdChk("count written", 32'h4, 32'hFD);
      bus(1'b1, 32'h0, 32'h90);
      rdChk("ctrl enable set", 32'h0, 32'hFE);
      bus(1'b1, 32'h0, 32'hA2);
      rdChk("stopped", 32'h0, 32'hFA);
      chk("run output", 32'h0, {31'h0, runEnable});
      bus(1'b1, 32'h8, 32'h00);
      rdChk("osc selected", 32'h8, 32'hF0);
      $display("register access test done");
      oscOn <= 1'b1;
      repeat (200) @(posedge clk_sys);
      rdChk("count held", 32'h4, 32'hFD);
      bus(1'b1, 32'h0, 32'hA6);
      waitFor(1'b1, 2000);
      chk("ticks to overflow", 32'h1, 32'(k >= 2 * 2 * OSCH && k <= 4 * 2 * OSCH));
      waitFor(1'b0, 1000);
      chk("pulse length", 32'h1, 32'(k >= 3 * 2 * OSCH && k <= 5 * 2 * OSCH));
      rdChk("flag set", 32'h0, 32'hFF);
      chk("flag output", 32'h1, {31'h0, overflowResetFlag});
      chk("hresp okay", 32'h0, {31'h0, hresp});
      bus(1'b1, 32'h0, 32'hA4);
      rdChk("flag cleared", 32'h0, 32'hFE);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rdChk("ctrl after reset", 32'h0, 32'hAE);
      $display("overflow and reset test done");
      tally_and_finish();
   end
endmodule
